/* File: rtcctl_top.sv */
// Clock/control register file, enable latches and shared alarm/frequency pin
//
// Summary of operation
// - Alarm drives the shared pin only with an enable set and frequency select zero.
// - Pulse mode with a single alarm enabled pulses the pin on every match.
// - Frequency select 00 alarm, 01 32.768kHz, 10 4096Hz, 11 1Hz from oscillator.
// - Any clock output selection suppresses the alarm function on the pin.
// - Digital trim varies oscillator counts per second to average out error.
// - Trim top bit is sign: 0 positive, 1 negative compensation.
// - Low magnitude bit gives 20ppm, high bit 10ppm, up to 30ppm.
// - Bus-off-on-battery set disables the serial bus on battery; default enabled.
// - Backup switch mode bit: 0 standard, 1 legacy which is default.
// - Three-bit reset level selects 4.64, 4.38, 3.09, 2.92 or 2.63 volts.
// - Reset level is nonvolatile; a control write with both latches set replaces the factory value.
// - Transfers start, send slave byte 11011110, an address, then stop.
// - Control writes start a programming cycle of up to 20ms; time writes fast.
// - Writes to undefined locations are ignored and change nothing.
// - A completed control space write clears the register write latch.
// - An aborted write leaves the register write latch set.
// - Writing zero to status clears both latches.
// - Reads between sequence steps do not disturb the pending sequence.
// - With both enables in pulse mode only alarm 0 pulses.
// - Pulsing continues until pulse mode or the alarm enables are cleared.
// - Single event mode holds the pin low until the alarm flag is read.
// - Status bit 2 is the register write latch, bit 1 the write latch.
`timescale 1ns/1ps
module rtcctl_top import rtcctl_pkg::*; #(
  parameter int unsigned NV_CYCLES   = NV_PROG_CYCLES,
  parameter logic [2:0]  VTS_FACTORY = VRST_4V64
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Two-wire serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Oscillator, supply state and alarm compare events
  input  wire logic        osc_i,
  input  wire logic        on_battery_i,
  input  wire logic        alarm0_match_i,
  input  wire logic        alarm1_match_i,
  // Shared alarm / frequency pin, open drain
  output logic             irq_fout_o,
  output logic             irq_fout_oe_o,
  // Configuration and status to the analog and supervisor blocks
  output logic [5:0]       trim_analog_o,
  output logic             backup_switch_mode_o,
  output logic [2:0]       reset_threshold_o,
  output logic             nv_busy_o,
  output logic             sec_tick_o
);

  localparam int NVW = $clog2(NV_CYCLES + 1);

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] ctl_wmask(input int i);
    case (i)
      IDX_BL:  return WM_BL;
      IDX_INT: return WM_INT;
      IDX_ATR: return WM_ATR;
      IDX_DTR: return WM_DTR;
      default: return WM_PWR;
    endcase
  endfunction

  // Trim magnitude scaled by counts per second, in millionths of a count
  function automatic logic [20:0] trim_weight(input logic [7:0] dtr);
    logic [20:0] ppm;
    ppm = (dtr[DTR_SMALL] ? 21'(PPM_STEP_SMALL) : 21'h000000)
        + (dtr[DTR_LARGE] ? 21'(PPM_STEP_LARGE) : 21'h000000);
    return ppm << OSC_LOG2;
  endfunction

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers and serial slave

  logic [1:0] s1_q, s2_q;
  logic       osc_d3_q;
  rtcctl_bus_if bus ();

  always_ff @(posedge clk_sys_i) begin
    s1_q <= {osc_i, on_battery_i};
    s2_q <= s1_q;
    osc_d3_q <= s2_q[1];
  end

  wire osc_lvl  = s2_q[1];
  wire on_batt  = s2_q[0];
  wire osc_rise = osc_lvl & ~osc_d3_q;

  rtcctl_i2c_slave u_slave (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_oe_o  (sda_oe_o),
    .bus       (bus.slave)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transaction tracking; data is staged and only committed at stop

  logic [7:0]          ctl_q [CTL_REGS];
  logic [7:0]          pend_q [CTL_REGS];
  logic [CTL_REGS-1:0] pmask_q;
  logic [1:0]          idx_q;
  logic                hi_ok_q;
  logic [7:0]          ptr_q, base_q, sr_pend_q;
  logic [3:0]          cnt_q;
  logic                wel_q, register_write_latch_q, al0_q, al1_q, rtcf_q;
  logic                nv_busy_q;
  logic [NVW-1:0]      nv_cnt_q;

  wire [7:0] base_end = base_q + {4'h0, cnt_q} - 8'h01;
  wire       latched  = wel_q & register_write_latch_q;
  wire       commit   = bus.stop & hi_ok_q & (cnt_q != 4'h0);
  wire       sr_ok    = commit & (base_q == ADDR_SR) & (cnt_q == 4'h1);
  wire       ctl_ok   = commit & latched & in_rng(base_q, ADDR_CTL_LO, ADDR_CTL_HI)
                      & (base_end <= ADDR_CTL_HI);
  wire       rtc_ok   = commit & latched & (base_q == ADDR_RTC_LO) & (cnt_q == RTC_BYTES);
  wire       ptr_ctl  = in_rng(ptr_q, ADDR_CTL_LO, ADDR_CTL_HI);
  wire [2:0] ptr_idx  = 3'(ptr_q - ADDR_CTL_LO);
  wire       sr_read  = bus.rd_stb & (ptr_q == ADDR_SR);
  wire [7:0] status   = {on_batt, al1_q, al0_q, 2'b00, register_write_latch_q, wel_q, rtcf_q};

  assign bus.rd_byte = (ptr_q == ADDR_SR) ? status : (ptr_ctl ? ctl_q[ptr_idx] : 8'h00);
  assign bus.busy    = nv_busy_q;
  assign bus.en      = ~(on_batt & ctl_q[IDX_PWR][PWR_BUS_OFF_ON_BATTERY]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus.start || bus.stop) begin
      idx_q <= 2'h0;
      cnt_q <= 4'h0;
      pmask_q <= '0;
    end else if (bus.wr_stb) begin
      idx_q <= (idx_q == 2'h2) ? idx_q : idx_q + 2'h1;
      if (idx_q == 2'h2 && cnt_q != 4'hF) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (idx_q == 2'h2 && ptr_ctl) begin
        pmask_q[ptr_idx] <= 1'b1;
      end
    end
  end

  // A random read reuses the pointer set by a preceding address-only write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_q <= 8'h00;
      base_q <= 8'h00;
      hi_ok_q <= 1'b0;
      sr_pend_q <= 8'h00;
    end else if (bus.wr_stb) begin
      unique case (idx_q)
        2'h0: hi_ok_q <= (bus.wr_byte == 8'h00);
        2'h1: begin
          ptr_q <= bus.wr_byte;
          base_q <= bus.wr_byte;
        end
        default: begin
          ptr_q <= ptr_q + 8'h01;
          if (ptr_q == ADDR_SR) begin
            sr_pend_q <= bus.wr_byte;
          end
        end
      endcase
    end else if (bus.rd_stb) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (bus.wr_stb && idx_q == 2'h2 && ptr_ctl) begin
      pend_q[ptr_idx] <= bus.wr_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable latches, alarm flags and the control registers

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wel_q <= 1'b0;
      register_write_latch_q <= 1'b0;
    end else if (sr_ok) begin
      unique case (sr_pend_q)
        SR_CLEAR: begin
          wel_q <= 1'b0;
          register_write_latch_q <= 1'b0;
        end
        SR_SET_WEL: begin
          wel_q <= 1'b1;
          register_write_latch_q <= 1'b0;
        end
        SR_SET_REGISTER_WRITE_LATCH: register_write_latch_q <= wel_q;
        default: ;
      endcase
    end else if (ctl_ok || rtc_ok) begin
      register_write_latch_q <= 1'b0;
    end
  end

  // Hardware set wins over the clear caused by reading the status byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      al0_q <= 1'b0;
      al1_q <= 1'b0;
      rtcf_q <= 1'b1;
    end else begin
      al0_q <= alarm0_match_i | (al0_q & ~sr_read);
      al1_q <= alarm1_match_i | (al1_q & ~sr_read);
      rtcf_q <= rtcf_q & ~rtc_ok;
    end
  end

  // Time values are accepted for the sequence but kept by the counting logic elsewhere
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < CTL_REGS; i++) begin
      if (rst_i) begin
        ctl_q[i] <= (i == IDX_BL) ? RST_BL : (i == IDX_INT) ? RST_INT :
                    (i == IDX_ATR) ? RST_ATR : (i == IDX_DTR) ? RST_DTR :
                    (RST_PWR | {5'h00, VTS_FACTORY});
      end else if (ctl_ok && pmask_q[i]) begin
        ctl_q[i] <= pend_q[i] & ctl_wmask(i);
      end
    end
  end

  // Busy refuses the device address so no transfer lands mid-programming
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nv_busy_q <= 1'b0;
      nv_cnt_q <= '0;
    end else if (ctl_ok) begin
      nv_busy_q <= 1'b1;
      nv_cnt_q <= NVW'(NV_CYCLES - 1);
    end else if (nv_cnt_q != '0) begin
      nv_cnt_q <= nv_cnt_q - 1'b1;
    end else begin
      nv_busy_q <= 1'b0;
    end
  end

  assign trim_analog_o        = ctl_q[IDX_ATR][5:0];
  assign backup_switch_mode_o = ctl_q[IDX_PWR][PWR_BSW];
  assign reset_threshold_o    = ctl_q[IDX_PWR][2:0];
  assign nv_busy_o            = nv_busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator division with digital trim

  logic [2:0]  div8_q;
  logic [15:0] sec_cnt_q;
  logic [19:0] acc_q;
  logic        skip_q, sec_tick_q;

  wire [7:0]  dtr      = ctl_q[IDX_DTR];
  wire [20:0] acc_sum  = {1'b0, acc_q} + trim_weight(dtr);
  wire        acc_wrap = acc_sum >= PPM_SCALE;
  // Positive trim means a slow crystal, so the adjusted second is one count shorter
  wire [15:0] sec_last = !skip_q ? SEC_LAST :
                         (dtr[DTR_SIGN] ? SEC_LAST + 16'h0001 : SEC_LAST - 16'h0001);
  wire        sec_end  = osc_rise & (sec_cnt_q >= sec_last);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div8_q <= 3'h0;
      sec_cnt_q <= 16'h0000;
    end else if (osc_rise) begin
      div8_q <= div8_q + 3'h1;
      sec_cnt_q <= sec_end ? 16'h0000 : sec_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_q <= 20'h00000;
      skip_q <= 1'b0;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= sec_end;
      if (sec_end) begin
        skip_q <= acc_wrap;
        acc_q <= acc_wrap ? 20'(acc_sum - PPM_SCALE) : acc_sum[19:0];
      end
    end
  end

  assign sec_tick_o = sec_tick_q;

  //////////////////////////////////////////////////////////////////////////////
  // Shared alarm / frequency pin

  logic [7:0] pulse_q;
  logic       irq_oe_q, irq_o_q, sda_o_q;

  rtcctl_fsel_type fsel;
  assign fsel = rtcctl_fsel_type'(ctl_q[IDX_INT][INT_FO_HI:INT_FO_LO]);
  wire im      = ctl_q[IDX_INT][INT_IM];
  wire alarm0_irq_enable    = ctl_q[IDX_INT][INT_ALARM0_IRQ_ENABLE];
  wire alarm1_irq_enable    = ctl_q[IDX_INT][INT_ALARM1_IRQ_ENABLE];
  wire alarm_on = (fsel == FSEL_ALARM) & (alarm0_irq_enable | alarm1_irq_enable);
  wire pulse_hit = im & (alarm0_irq_enable ? alarm0_match_i : (alarm1_irq_enable & alarm1_match_i));
  wire level_low = (alarm0_irq_enable & al0_q) | (alarm1_irq_enable & al1_q);
  logic irq_low;

  always_comb begin
    unique case (fsel)
      FSEL_ALARM: irq_low = alarm_on & (im ? (pulse_q != 8'h00) : level_low);
      FSEL_32K:   irq_low = ~osc_lvl;
      FSEL_4096:  irq_low = ~div8_q[2];
      FSEL_1HZ:   irq_low = sec_cnt_q >= SEC_HALF;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pulse_q <= 8'h00;
    end else if (pulse_hit && alarm_on) begin
      pulse_q <= IRQ_PULSE_CYCLES;
    end else if (pulse_q != 8'h00) begin
      pulse_q <= pulse_q - 8'h01;
    end
  end

  // Open-drain pins only ever pull low, so their data bits stay at zero
  always_ff @(posedge clk_sys_i) begin
    irq_oe_q <= !rst_i && irq_low;
    irq_o_q <= 1'b0;
    sda_o_q <= 1'b0;
  end

  assign irq_fout_oe_o = irq_oe_q;
  assign irq_fout_o    = irq_o_q;
  assign sda_o         = sda_o_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_ALARM_HOLD: assert property (
    (fsel == FSEL_ALARM) && !im && alarm0_irq_enable && al0_q && !sr_read ##1 (fsel == FSEL_ALARM)
    |=> irq_fout_oe_o) else $error("single event alarm not held on pin");
  AST_PULSE: assert property (
    (fsel == FSEL_ALARM) && im && alarm0_irq_enable && alarm0_match_i ##1 $stable(ctl_q[IDX_INT])
    |=> irq_fout_oe_o) else $error("pulse mode match gave no pulse");
  AST_AL1_MASKED: assert property (
    im && alarm0_irq_enable && alarm1_irq_enable && alarm1_match_i && !alarm0_match_i && pulse_q == 8'h00
    |=> pulse_q == 8'h00) else $error("alarm 1 pulsed although alarm 0 overrides");
  AST_FREQ_OUT: assert property (
    fsel == FSEL_32K && alarm0_match_i ##1 fsel == FSEL_32K
    |=> irq_fout_oe_o == !$past(osc_lvl)) else $error("clock output not on pin");
  AST_REGISTER_WRITE_LATCH_CLEAR: assert property (
    ctl_ok |=> !register_write_latch_q ##1 !register_write_latch_q || $past(sr_ok)) else $error("latch kept after commit");
  AST_UNLATCHED: assert property (
    bus.stop && !latched |=> $stable(ctl_q[IDX_PWR]) && $stable(ctl_q[IDX_DTR]))
    else $error("control changed without both latches");
  AST_ZERO_CLEAR: assert property (
    sr_ok && sr_pend_q == SR_CLEAR |=> !wel_q && !register_write_latch_q) else $error("zero write kept latch");
  AST_READ_KEEPS: assert property (
    bus.rd_stb && !bus.stop |=> $stable(register_write_latch_q) && $stable(wel_q))
    else $error("read disturbed latches");
  AST_NV_BUSY: assert property (
    ctl_ok |=> nv_busy_o [*8]) else $error("no programming cycle after control write");
  AST_ABORT: assert property (
    bus.start && register_write_latch_q && !sr_ok |=> register_write_latch_q) else $error("aborted write cleared latch");

endmodule

/* File: rtcctl_pkg.sv */
// Constants, field positions and types shared by the clock control register block
package rtcctl_pkg;

  // Timing
  localparam int CLK_HZ         = 250_000_000;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int NV_PROG_MS     = 20;
  localparam int NV_PROG_CYCLES = CLK_HZ / 1000 * NV_PROG_MS;
  localparam int IRQ_PULSE_NS   = 1000;
  localparam logic [7:0] IRQ_PULSE_CYCLES = 8'(IRQ_PULSE_NS / CLK_PERIOD_NS);

  // Oscillator division and trim arithmetic
  localparam int OSC_HZ = 32768;
  localparam int OSC_LOG2 = 15;
  localparam logic [15:0] SEC_LAST = 16'(OSC_HZ - 1);
  localparam logic [15:0] SEC_HALF = 16'(OSC_HZ / 2);
  localparam int PPM_STEP_SMALL = 10;
  localparam int PPM_STEP_LARGE = 20;
  localparam logic [20:0] PPM_SCALE = 21'(1_000_000);

  // Bus address and register space
  localparam logic [6:0] DEV_ADDR    = 7'h6F;
  localparam logic [7:0] ADDR_CTL_LO = 8'h10;
  localparam logic [7:0] ADDR_CTL_HI = 8'h14;
  localparam logic [7:0] ADDR_RTC_LO = 8'h30;
  localparam logic [7:0] ADDR_SR     = 8'h3F;
  localparam logic [3:0] RTC_BYTES   = 4'h8;
  localparam int CTL_REGS = 5;
  localparam int IDX_BL   = 0;
  localparam int IDX_INT  = 1;
  localparam int IDX_ATR  = 2;
  localparam int IDX_DTR  = 3;
  localparam int IDX_PWR  = 4;

  // Status register layout and the enable sequence values
  localparam int SR_BAT  = 7;
  localparam int SR_AL1  = 6;
  localparam int SR_AL0  = 5;
  localparam int SR_REGISTER_WRITE_LATCH = 2;
  localparam int SR_WEL  = 1;
  localparam int SR_RTCF = 0;
  localparam logic [7:0] SR_CLEAR    = 8'h00;
  localparam logic [7:0] SR_SET_WEL  = 8'h02;
  localparam logic [7:0] SR_SET_REGISTER_WRITE_LATCH = 8'h06;

  // Control field positions
  localparam int INT_IM = 7;
  localparam int INT_ALARM1_IRQ_ENABLE = 6;
  localparam int INT_ALARM0_IRQ_ENABLE = 5;
  localparam int INT_FO_HI = 4;
  localparam int INT_FO_LO = 3;
  localparam int DTR_SIGN = 2;
  localparam int DTR_SMALL = 1;
  localparam int DTR_LARGE = 0;
  localparam int PWR_BUS_OFF_ON_BATTERY = 7;
  localparam int PWR_BSW = 6;

  // Reset values and writable bits
  localparam logic [7:0] RST_BL  = 8'h18;
  localparam logic [7:0] RST_INT = 8'h00;
  localparam logic [7:0] RST_ATR = 8'h00;
  localparam logic [7:0] RST_DTR = 8'h00;
  localparam logic [7:0] RST_PWR = 8'h40;
  localparam logic [7:0] WM_BL   = 8'hF8;
  localparam logic [7:0] WM_INT  = 8'hF8;
  localparam logic [7:0] WM_ATR  = 8'h3F;
  localparam logic [7:0] WM_DTR  = 8'h07;
  localparam logic [7:0] WM_PWR  = 8'hC7;

  typedef enum logic [1:0] {
    FSEL_ALARM = 2'h0, FSEL_32K = 2'h1, FSEL_4096 = 2'h2, FSEL_1HZ = 2'h3
  } rtcctl_fsel_type;

  // Supply reset thresholds: 4.64, 4.38, 3.09, 2.92, 2.63 volts
  typedef enum logic [2:0] {
    VRST_4V64 = 3'h0, VRST_4V38 = 3'h1, VRST_3V09 = 3'h2, VRST_2V92 = 3'h3,
    VRST_2V63 = 3'h4
  } rtcctl_vrst_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_RX = 5'h02, ST_ACK = 5'h04, ST_TX = 5'h08, ST_TXACK = 5'h10
  } rtcctl_st_type;

endpackage

/* File: rtcctl_bus_if.sv */
// Byte-level link between the serial slave and the register file
`timescale 1ns/1ps
interface rtcctl_bus_if;
  logic       start;
  logic       stop;
  logic       wr_stb;
  logic [7:0] wr_byte;
  logic       rd_stb;
  logic [7:0] rd_byte;
  logic       busy;
  logic       en;
  modport slave (output start, stop, wr_stb, wr_byte, rd_stb, input rd_byte, busy, en);
  modport regs  (input start, stop, wr_stb, wr_byte, rd_stb, output rd_byte, busy, en);
endinterface

/* File: rtcctl_i2c_slave.sv */
// Two-wire serial slave: start/stop detection, byte shifting and acknowledge
`timescale 1ns/1ps
module rtcctl_i2c_slave import rtcctl_pkg::*; (
  // Clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    rst_i,
  // Bus pins
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  output logic         sda_oe_o,
  // Register side
  rtcctl_bus_if.slave  bus
);

  logic [1:0]    p1_q, p2_q, p3_q;
  rtcctl_st_type st_q;
  logic [7:0]    sh_q;
  logic [3:0]    bcnt_q;
  logic          first_q;
  logic          rd_q;

  // The second and third stages feed logic; the first is purely metastability settling
  always_ff @(posedge clk_sys_i) begin
    p1_q <= {scl_i, sda_i};
    p2_q <= p1_q;
    p3_q <= p2_q;
  end

  wire scl     = p2_q[1];
  wire sda     = p2_q[0];
  wire start_w = scl & p3_q[1] & p3_q[0] & ~sda;
  wire stop_w  = scl & p3_q[1] & ~p3_q[0] & sda;
  wire rise    = scl & ~p3_q[1];
  wire fall    = ~scl & p3_q[1];
  wire addr_ok = (sh_q[7:1] == DEV_ADDR) & ~bus.busy;

  always_ff @(posedge clk_sys_i) begin
    bus.start  <= 1'b0;
    bus.stop   <= 1'b0;
    bus.wr_stb <= 1'b0;
    bus.rd_stb <= 1'b0;
    if (rst_i) begin
      st_q <= ST_IDLE;
      sda_oe_o <= 1'b0;
      sh_q <= 8'h00;
      bcnt_q <= 4'h0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      bus.wr_byte <= 8'h00;
    end else if (!bus.en || stop_w) begin
      st_q <= ST_IDLE;
      sda_oe_o <= 1'b0;
      bus.stop <= stop_w & bus.en;
    end else if (start_w) begin
      st_q <= ST_RX;
      bcnt_q <= 4'h0;
      first_q <= 1'b1;
      sda_oe_o <= 1'b0;
      bus.start <= 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE: ;
        ST_RX: begin
          if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            bcnt_q <= bcnt_q + 4'h1;
          end else if (fall && bcnt_q == 4'h8) begin
            first_q <= 1'b0;
            if (!first_q || addr_ok) begin
              sda_oe_o <= 1'b1;
              st_q <= ST_ACK;
            end else begin
              st_q <= ST_IDLE;
            end
            if (first_q) begin
              rd_q <= sh_q[0];
            end else begin
              bus.wr_stb <= 1'b1;
              bus.wr_byte <= sh_q;
            end
          end
        end
        ST_ACK, ST_TXACK: begin
          if (st_q == ST_TXACK && rise && sda) begin
            st_q <= ST_IDLE;
          end else if (fall && rd_q) begin
            sh_q <= bus.rd_byte;
            sda_oe_o <= ~bus.rd_byte[7];
            bcnt_q <= 4'h1;
            bus.rd_stb <= 1'b1;
            st_q <= ST_TX;
          end else if (fall) begin
            sda_oe_o <= 1'b0;
            bcnt_q <= 4'h0;
            st_q <= ST_RX;
          end
        end
        ST_TX: begin
          if (fall && bcnt_q == 4'h8) begin
            sda_oe_o <= 1'b0;
            st_q <= ST_TXACK;
          end else if (fall) begin
            sda_oe_o <= ~sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
            bcnt_q <= bcnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  AST_BUS_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !bus.en |=> !sda_oe_o && !bus.wr_stb) else $error("slave active while disabled");

endmodule

/* File: rtcctl_host_model.sv */
// Two-wire bus host model: start, stop and byte transfers
`timescale 1ns/1ps
module rtcctl_host_model (
  // Clock
  input  wire logic clk_sys_i,
  // Bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Four quarters make one bus bit of about 125 ns
  task automatic qtr();
    repeat (8) @(negedge clk_sys_i);
  endtask
  // Data only moves while the bus clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    qtr();
    scl_o = 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_oe_o = 1'b1;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_oe_o = 1'b0;
    qtr();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mack, r);
    ack = ~r;
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the clock control register block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb import rtcctl_pkg::*;;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       osc_i = 1'b0;
  logic       al0_i = 1'b0;
  logic       bat_i = 1'b0;
  logic       scl, host_oe, sda_oe, irq_oe, backup_switch_mode, nvb, write_latch, register_write_latch;
  logic [5:0] trim;
  logic [2:0] vts;
  wire        sda = ~(host_oe | sda_oe);
  logic [7:0] m[5] = '{RST_BL, RST_INT, RST_ATR, RST_DTR, RST_PWR};
  int         num_errors = 0;
  int         n_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  always begin
    repeat (3815) @(negedge clk_sys_i);
    osc_i = ~osc_i;
  end
  rtcctl_top #(.NV_CYCLES(20)) dut (.clk_sys_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .osc_i, .on_battery_i(bat_i), .alarm0_match_i(al0_i),
    .alarm1_match_i(1'b0), .irq_fout_o(), .irq_fout_oe_o(irq_oe), .trim_analog_o(trim),
    .backup_switch_mode_o(backup_switch_mode), .reset_threshold_o(vts), .nv_busy_o(nvb), .sec_tick_o());
  rtcctl_host_model host (.clk_sys_i, .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hdr(input logic [7:0] a);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer(8'hDE, 1'b1, q, k);
    `CHK(k, 1'b1)
    host.xfer(8'h00, 1'b1, q, k);
    host.xfer(a, 1'b1, q, k);
  endtask
  // Writes also step the reference model of registers and latches
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic [7:0] q;
    logic k;
    hdr(a);
    foreach (d[i]) host.xfer(d[i], 1'b1, q, k);
    host.stop();
    repeat (8) @(negedge clk_sys_i);
    if (a == ADDR_SR) begin
      if (d[0] == SR_CLEAR || d[0] == SR_SET_WEL) {register_write_latch, write_latch} = {1'b0, d[0][SR_WEL]};
      if (d[0] == SR_SET_REGISTER_WRITE_LATCH) register_write_latch = write_latch;
    end else if (register_write_latch && a >= ADDR_CTL_LO && a + d.size() <= ADDR_CTL_HI + 1) begin
      foreach (d[i]) m[a - ADDR_CTL_LO + i] = d[i];
      register_write_latch = 1'b0;
    end
  endtask
  task automatic rd_sr(output logic [7:0] q);
    logic k;
    hdr(ADDR_SR);
    host.start();
    host.xfer(8'hDF, 1'b1, q, k);
    host.xfer(8'hFF, 1'b1, q, k);
    host.stop();
    repeat (8) @(negedge clk_sys_i);
  endtask
  task automatic chk_all();
    logic [7:0] q;
    rd_sr(q);
    `CHK(q[SR_REGISTER_WRITE_LATCH], register_write_latch)
    `CHK(q[SR_WEL], write_latch)
    `CHK(trim, m[IDX_ATR][5:0])
    `CHK(backup_switch_mode, m[IDX_PWR][PWR_BSW])
    `CHK(vts, m[IDX_PWR][2:0])
  endtask
  task automatic unlock(input logic [7:0] v);
    wr(ADDR_SR, '{SR_SET_WEL});
    wr(ADDR_SR, '{SR_SET_REGISTER_WRITE_LATCH});
    wr(8'h11, '{v});
    for (int n = 0; nvb !== 1'b0; n++) begin
      if (n > 200) begin
        num_errors++;
        finish_test();
      end
      @(negedge clk_sys_i);
    end
  endtask
  task automatic hit();
    al0_i = 1'b1;
    @(negedge clk_sys_i);
    al0_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    logic       k;
    {write_latch, register_write_latch} = 2'b00;
    void'($urandom(3));
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    chk_all();
    for (int i = 0; i < 3; i++) begin
      wr(8'h12, '{8'($urandom), 8'($urandom)});
      wr(ADDR_SR, '{SR_SET_WEL});
      chk_all();
      wr(ADDR_SR, '{SR_SET_REGISTER_WRITE_LATCH});
      if (i == 1) wr(8'h15, '{8'h00});
      chk_all();
      wr(8'h12, '{8'($urandom), 8'($urandom), {2'($urandom), 3'h0, 3'($urandom % 5)}});
      `CHK(nvb, 1'b1)
      chk_all();
      wr(ADDR_SR, '{SR_CLEAR});
      chk_all();
    end
    // On battery the address is only answered while the bus-off bit is clear
    bat_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    host.start();
    host.xfer(8'hDE, 1'b1, q, k);
    host.stop();
    `CHK(k, ~m[IDX_PWR][PWR_BUS_OFF_ON_BATTERY])
    bat_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    // Pulse mode with alarm 0: every match gives a fresh pulse
    unlock(8'hA0);
    for (int i = 0; i < 2; i++) begin
      hit();
      `CHK(irq_oe, 1'b1)
      repeat (IRQ_PULSE_CYCLES) @(negedge clk_sys_i);
      `CHK(irq_oe, 1'b0)
    end
    rd_sr(q);
    unlock(8'h20);
    hit();
    `CHK(irq_oe, 1'b1)
    rd_sr(q);
    `CHK(q[SR_AL0], 1'b1)
    `CHK(irq_oe, 1'b0)
    unlock(8'h28);
    hit();
    `CHK(irq_oe, ~osc_i)
    finish_test();
  end
endmodule
